// *** design/dtio_pkg.sv ***
// Package for the drive terminal I/O logic: function codes, relay sources, types.
// Assumes a 20 MHz control clock.
package dtio_pkg;
  // ----------------------------------------
  // Sizes and clock
  // ----------------------------------------
  localparam int NUM_TERMS = 4;
  localparam int FUNC_W = 6;
  localparam int RSRC_W = 6;
  localparam int CLK_HZ = 20000000;
  localparam int FILT_MAX_MS = 1000;
  localparam int FILT_DEF_MS = 10;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int FILT_DEF_CYC = FILT_DEF_MS * CYC_PER_MS;
  localparam int FILT_CNT_W = 25;
  localparam int CNT_MAX_HZ = 250;
  localparam int CNT_W = 16;
  localparam logic [1:0] CTRL_DEF = 2'h0;
  // ----------------------------------------
  // Input terminal function codes
  // ----------------------------------------
  localparam logic [FUNC_W-1:0] FN_NONE = 6'h00;
  localparam logic [FUNC_W-1:0] FN_FWD = 6'h06;
  localparam logic [FUNC_W-1:0] FN_REV = 6'h07;
  localparam logic [FUNC_W-1:0] FN_SPD1 = 6'h09;
  localparam logic [FUNC_W-1:0] FN_RAMP1 = 6'h0d;
  localparam logic [FUNC_W-1:0] FN_RAMP2 = 6'h0e;
  localparam logic [FUNC_W-1:0] FN_UP = 6'h0f;
  localparam logic [FUNC_W-1:0] FN_DOWN = 6'h10;
  localparam logic [FUNC_W-1:0] FN_HALT = 6'h11;
  localparam logic [FUNC_W-1:0] FN_RST = 6'h12;
  localparam logic [FUNC_W-1:0] FN_PID = 6'h13;
  localparam logic [FUNC_W-1:0] FN_SEQ = 6'h14;
  localparam logic [FUNC_W-1:0] FN_TMR1 = 6'h15;
  localparam logic [FUNC_W-1:0] FN_TMR2 = 6'h16;
  localparam logic [FUNC_W-1:0] FN_CPULSE = 6'h17;
  localparam logic [FUNC_W-1:0] FN_CCLR = 6'h18;
  localparam logic [FUNC_W-1:0] FN_PAUSE = 6'h19;
  localparam logic [FUNC_W-1:0] FN_CHAN = 6'h1a;
  // ----------------------------------------
  // Relay source codes
  // ----------------------------------------
  localparam logic [RSRC_W-1:0] RS_NONE = 6'h00;
  localparam logic [RSRC_W-1:0] RS_RUN = 6'h01;
  localparam logic [RSRC_W-1:0] RS_REACH = 6'h02;
  localparam logic [RSRC_W-1:0] RS_FAULT = 6'h03;
  localparam logic [RSRC_W-1:0] RS_ZERO = 6'h04;
  localparam logic [RSRC_W-1:0] RS_ACC = 6'h07;
  localparam logic [RSRC_W-1:0] RS_DEC = 6'h08;
  localparam logic [RSRC_W-1:0] RS_UV = 6'h09;
  localparam logic [RSRC_W-1:0] RS_TMR1 = 6'h0a;
  localparam logic [RSRC_W-1:0] RS_TMR2 = 6'h0b;
  localparam logic [RSRC_W-1:0] RS_STEP = 6'h0c;
  localparam logic [RSRC_W-1:0] RS_PROG = 6'h0d;
  localparam logic [RSRC_W-1:0] RS_PIDHI = 6'h0e;
  localparam logic [RSRC_W-1:0] RS_PIDLO = 6'h0f;
  localparam logic [RSRC_W-1:0] RS_MAX = 6'h20;
  localparam logic [RSRC_W-1:0] RS_DEF = RS_FAULT;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DTIO_DIR_STOP,
    DTIO_DIR_FWD,
    DTIO_DIR_REV
  } dtio_dir_t;
  typedef struct packed {
    logic run;
    logic freq_reached;
    logic fault;
    logic below_start;
    logic accel;
    logic decel;
    logic undervolt;
    logic tmr1_done;
    logic tmr2_done;
    logic step_done;
    logic prog_done;
    logic pid_above;
    logic pid_below;
  } dtio_status_t;
  typedef struct packed {
    logic [3:0] speed_sel;
    logic [1:0] ramp_sel;
    logic freq_up;
    logic freq_down;
    logic halt;
    logic fault_clr;
    logic pid_en;
    logic seq_start;
    logic tmr1_run;
    logic tmr2_run;
    logic pause;
    logic chan_y;
  } dtio_cmd_t;
endpackage

// *** design/dtio_top.sv ***
// Terminal decoding, relay source selection and relay filter of a motor drive.
// Assumes terminal inputs synchronous to i_clk and already debounced.
`timescale 1ns/100ps
module dtio_top import dtio_pkg::*; #(
  parameter int FILT_DEF = dtio_pkg::FILT_DEF_CYC // Filter cycles after reset
) (
  input wire logic i_clk, // 20 MHz control clock
  input wire logic i_arst_n, // Async reset, active low
  input wire logic [dtio_pkg::NUM_TERMS-1:0] i_term, // Input terminal levels
  input wire logic [dtio_pkg::NUM_TERMS*dtio_pkg::FUNC_W-1:0] i_term_func, // Function code per terminal
  input wire logic [dtio_pkg::RSRC_W-1:0] i_relay_source_select, // Relay source code
  input wire logic [dtio_pkg::FILT_CNT_W-1:0] i_relay_filter_time, // Filter length in cycles
  input wire logic i_filter_load, // Take new filter length
  input wire logic [1:0] i_terminal_control_method, // Control method code
  input wire logic i_trim_save_option, // Keep trim over power-off
  input wire dtio_pkg::dtio_status_t i_status, // Drive status conditions
  output dtio_pkg::dtio_cmd_t o_cmd, // Decoded terminal commands
  output dtio_pkg::dtio_dir_t o_dir, // Run direction command
  output logic o_trim_keep, // Keep trimmed setpoint
  output logic o_uv_alarm, // Undervoltage alarm, only while the relay source code is undervoltage
  output logic [dtio_pkg::CNT_W-1:0] o_count, // Pulse counter value
  output logic o_programmable_relay // Relay drive, high closes
);
  import dtio_pkg::*;

  // ----------------------------------------
  // Terminal function decode
  // ----------------------------------------
  function automatic logic any_term(input logic [NUM_TERMS*FUNC_W-1:0] funcs,
                                    input logic [NUM_TERMS-1:0] lv, input logic [FUNC_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < NUM_TERMS; k++) begin
      if (lv[k] && funcs[k*FUNC_W +: FUNC_W] == code) hit = 1'b1;
    end
    return hit;
  endfunction

  // Speed select bits from function codes 9..12
  logic [3:0] spd_w;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_spd
      assign spd_w[g] = any_term(i_term_func, i_term, FN_SPD1 + 6'(g));
    end
  endgenerate

  // Command wires; unlisted and reserved codes match nothing
  wire ramp1_w = any_term(i_term_func, i_term, FN_RAMP1);
  wire ramp2_w = any_term(i_term_func, i_term, FN_RAMP2);
  wire up_w = any_term(i_term_func, i_term, FN_UP);
  wire down_w = any_term(i_term_func, i_term, FN_DOWN);
  wire halt_w = any_term(i_term_func, i_term, FN_HALT);
  wire rst_w = any_term(i_term_func, i_term, FN_RST);
  wire pid_w = any_term(i_term_func, i_term, FN_PID);
  wire seq_w = any_term(i_term_func, i_term, FN_SEQ);
  wire t1_w = any_term(i_term_func, i_term, FN_TMR1);
  wire t2_w = any_term(i_term_func, i_term, FN_TMR2);
  wire cp_w = any_term(i_term_func, i_term, FN_CPULSE);
  wire cc_w = any_term(i_term_func, i_term, FN_CCLR);
  wire pause_w = any_term(i_term_func, i_term, FN_PAUSE);
  wire chan_w = any_term(i_term_func, i_term, FN_CHAN);
  wire fwd_w = any_term(i_term_func, i_term, FN_FWD);
  wire rev_w = any_term(i_term_func, i_term, FN_REV);

  // Ramp set index: ramp 1 function code is bit 0
  wire [1:0] ramp_w = {ramp2_w, ramp1_w};
  // Raise and lower together cancel
  wire up_only_w = up_w & ~down_w;
  wire down_only_w = down_w & ~up_w;

  // Direction per control method; three-wire modes out of scope, stop
  dtio_dir_t dir_w;
  assign dir_w = (i_terminal_control_method != CTRL_DEF) ? DTIO_DIR_STOP :
                 (fwd_w && !rev_w) ? DTIO_DIR_FWD :
                 (rev_w && !fwd_w) ? DTIO_DIR_REV : DTIO_DIR_STOP;

  // Registered command outputs
  dtio_cmd_t cmd_d, cmd_q;
  dtio_dir_t dir_q;
  assign cmd_d = '{speed_sel: spd_w, ramp_sel: ramp_w, freq_up: up_only_w, freq_down: down_only_w,
                   halt: halt_w, fault_clr: rst_w, pid_en: pid_w, seq_start: seq_w, tmr1_run: t1_w,
                   tmr2_run: t2_w, pause: pause_w, chan_y: chan_w};
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cmd_q <= '0;
      dir_q <= DTIO_DIR_STOP;
    end else begin
      cmd_q <= cmd_d;
      dir_q <= dir_w;
    end
  end
  assign o_cmd = cmd_q;
  assign o_dir = dir_q;

  // ----------------------------------------
  // Trim save and pulse counter
  // ----------------------------------------
  logic trim_q;
  logic cp_q;
  logic [CNT_W-1:0] cnt_q;
  wire cp_rise_w = cp_w & ~cp_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      trim_q <= 1'b0;
      cp_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      trim_q <= i_trim_save_option;
      cp_q <= cp_w;
      if (cc_w) cnt_q <= '0;
      else if (cp_rise_w) cnt_q <= cnt_q + 16'h0001;
    end
  end
  assign o_trim_keep = trim_q;
  assign o_count = cnt_q;

  // ----------------------------------------
  // Relay source selection
  // ----------------------------------------
  logic [RSRC_W-1:0] rsrc_q;
  logic src_w;
  always_comb begin
    case (rsrc_q)
      RS_RUN: src_w = i_status.run;
      RS_REACH: src_w = i_status.freq_reached;
      RS_FAULT: src_w = i_status.fault;
      RS_ZERO: src_w = i_status.below_start;
      RS_ACC: src_w = i_status.accel;
      RS_DEC: src_w = i_status.decel;
      RS_UV: src_w = i_status.undervolt;
      RS_TMR1: src_w = i_status.tmr1_done & t1_w;
      RS_TMR2: src_w = i_status.tmr2_done & t2_w;
      RS_STEP: src_w = i_status.step_done;
      RS_PROG: src_w = i_status.prog_done;
      RS_PIDHI: src_w = i_status.pid_above;
      RS_PIDLO: src_w = i_status.pid_below;
      default: src_w = 1'b0;
    endcase
  end
  // Source code register; out-of-range code falls back to none
  wire [RSRC_W-1:0] rsrc_d = (i_relay_source_select > RS_MAX) ? RS_NONE : i_relay_source_select;
  logic uv_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rsrc_q <= RS_DEF;
      uv_q <= 1'b0;
    end else begin
      rsrc_q <= rsrc_d;
      uv_q <= (rsrc_q == RS_UV) & i_status.undervolt;
    end
  end
  assign o_uv_alarm = uv_q;

  // ----------------------------------------
  // Relay response filter
  // ----------------------------------------
  // Pulse sources bypass the filter so short pulses are not swallowed
  wire pulse_src_w = (rsrc_q == RS_STEP) || (rsrc_q == RS_PROG);
  localparam logic [FILT_CNT_W-1:0] FILT_LIM = FILT_CNT_W'(FILT_MAX_MS * CYC_PER_MS);
  logic [FILT_CNT_W-1:0] flen_q, fcnt_q;
  logic relay_q;
  wire [FILT_CNT_W-1:0] flen_d = (i_relay_filter_time > FILT_LIM) ? FILT_LIM : i_relay_filter_time;
  wire differ_w = src_w != relay_q;
  wire fdone_w = fcnt_q >= flen_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flen_q <= FILT_CNT_W'(FILT_DEF);
      fcnt_q <= '0;
      relay_q <= 1'b0;
    end else begin
      if (i_filter_load) flen_q <= flen_d;
      if (!differ_w || pulse_src_w) begin
        fcnt_q <= '0;
        relay_q <= src_w;
      end else if (fdone_w) begin
        fcnt_q <= '0;
        relay_q <= src_w;
      end else begin
        fcnt_q <= fcnt_q + 25'h0000001;
      end
    end
  end
  assign o_programmable_relay = relay_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_speed;
    @(posedge i_clk) disable iff (!i_arst_n) 1'b1 |=> o_cmd.speed_sel == $past(spd_w);
  endproperty
  a_speed: assert property (p_speed) else $error("speed select wrong");
  property p_ramp;
    @(posedge i_clk) disable iff (!i_arst_n) 1'b1 |=> o_cmd.ramp_sel == {$past(ramp2_w), $past(ramp1_w)};
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp select wrong");
  property p_updown;
    @(posedge i_clk) disable iff (!i_arst_n) up_w |=> o_cmd.freq_up == !$past(down_w);
  endproperty
  a_updown: assert property (p_updown) else $error("raise and lower both set");
  property p_halt;
    @(posedge i_clk) disable iff (!i_arst_n) halt_w |=> o_cmd.halt;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not issued");
  property p_cnt_clr;
    @(posedge i_clk) disable iff (!i_arst_n) cc_w |=> o_count == 16'h0000;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("counter not cleared");
  property p_dir;
    @(posedge i_clk) disable iff (!i_arst_n)
      (i_terminal_control_method == CTRL_DEF && fwd_w && rev_w) |=> o_dir == DTIO_DIR_STOP;
  endproperty
  a_dir: assert property (p_dir) else $error("both inputs not stop");
  property p_none;
    @(posedge i_clk) disable iff (!i_arst_n) (rsrc_q == RS_NONE && !relay_q) |=> !relay_q;
  endproperty
  a_none: assert property (p_none) else $error("relay on with no source");
  property p_uv;
    @(posedge i_clk) disable iff (!i_arst_n) (rsrc_q == RS_UV && i_status.undervolt) |=> o_uv_alarm;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage alarm missing");
  property p_filt;
    @(posedge i_clk) disable iff (!i_arst_n) (differ_w && !pulse_src_w && !fdone_w) |=> $stable(relay_q);
  endproperty
  a_filt: assert property (p_filt) else $error("relay changed before filter");
  property p_down;
    @(posedge i_clk) disable iff (!i_arst_n) down_w |=> o_cmd.freq_down == !$past(up_w);
  endproperty
  a_down: assert property (p_down) else $error("lower command wrong");
  property p_trim;
    @(posedge i_clk) disable iff (!i_arst_n) 1'b1 |=> o_trim_keep == $past(i_trim_save_option);
  endproperty
  a_trim: assert property (p_trim) else $error("trim keep wrong");
  property p_fault_clr;
    @(posedge i_clk) disable iff (!i_arst_n) 1'b1 |=> o_cmd.fault_clr == $past(rst_w);
  endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault clear wrong");
  property p_pid;
    @(posedge i_clk) disable iff (!i_arst_n) 1'b1 |=> o_cmd.pid_en == $past(pid_w) && o_cmd.seq_start == $past(seq_w);
  endproperty
  a_pid: assert property (p_pid) else $error("regulator or sequencer enable wrong");
  property p_tmr;
    @(posedge i_clk) disable iff (!i_arst_n) 1'b1 |=> o_cmd.tmr1_run == $past(t1_w) && o_cmd.tmr2_run == $past(t2_w);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer start wrong");
  property p_cnt_inc;
    @(posedge i_clk) disable iff (!i_arst_n) (cp_rise_w && !cc_w) |=> o_count == $past(o_count) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("pulse not counted");
  property p_pause;
    @(posedge i_clk) disable iff (!i_arst_n) 1'b1 |=> o_cmd.pause == $past(pause_w);
  endproperty
  a_pause: assert property (p_pause) else $error("pause command wrong");
  property p_chan;
    @(posedge i_clk) disable iff (!i_arst_n) 1'b1 |=> o_cmd.chan_y == $past(chan_w);
  endproperty
  a_chan: assert property (p_chan) else $error("channel select wrong");
  property p_rsrc_range;
    @(posedge i_clk) disable iff (!i_arst_n) (i_relay_source_select > RS_MAX) |=> rsrc_q == RS_NONE;
  endproperty
  a_rsrc_range: assert property (p_rsrc_range) else $error("reserved source not ignored");
  property p_pulse;
    @(posedge i_clk) disable iff (!i_arst_n) pulse_src_w |=> relay_q == $past(src_w);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse source delayed by filter");
  property p_follow;
    @(posedge i_clk) disable iff (!i_arst_n) (differ_w && fdone_w) |=> relay_q == $past(src_w);
  endproperty
  a_follow: assert property (p_follow) else $error("relay not updated after filter");
  property p_method;
    @(posedge i_clk) disable iff (!i_arst_n) (i_terminal_control_method != CTRL_DEF) |=> o_dir == DTIO_DIR_STOP;
  endproperty
  a_method: assert property (p_method) else $error("unsupported method not stop");
  c_fwd: cover property (@(posedge i_clk) disable iff (!i_arst_n) o_dir == DTIO_DIR_FWD);
  c_relay: cover property (@(posedge i_clk) disable iff (!i_arst_n) $rose(o_programmable_relay));
  c_count: cover property (@(posedge i_clk) disable iff (!i_arst_n) o_count == 16'h0003);
  c_rev: cover property (@(posedge i_clk) disable iff (!i_arst_n) o_dir == DTIO_DIR_REV);
  c_pulse: cover property (@(posedge i_clk) disable iff (!i_arst_n) pulse_src_w && $rose(relay_q));
endmodule

// *** bench/dtio_contacts.sv ***
// External contacts and a pulse source that feed the four input terminals.
// Assumes bench requests change just after a rising clock edge, dtio_pkg compiled first.
`timescale 1ns/100ps
module dtio_contacts #(
  parameter int PERIOD = dtio_pkg::CLK_HZ / dtio_pkg::CNT_MAX_HZ, // Cycles between pulse rises
  parameter int HIGH = 4 // Cycles a pulse stays high
) (
  input wire logic i_clk, // Control clock
  input wire logic i_arst_n, // Reset, active low
  input wire logic [3:0] i_close, // Requested contact states
  input wire logic [7:0] i_npulse, // Pulses to send on contact 3
  input wire logic i_go, // Start a pulse burst
  output logic [3:0] o_term, // Terminal levels
  output logic o_busy // Burst in progress
);
  logic [7:0] left_q;
  logic [16:0] since_q;
  logic lvl_q;
  // Next rise only once a full period has passed since the last one
  wire ready_w = since_q >= 17'(PERIOD - 1);
  wire fire_w = !i_go && (left_q != 8'h00) && ready_w;
  // Pulse burst, rises spaced by the period so the counter rate limit is kept
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      left_q <= 8'h00;
      since_q <= 17'(PERIOD - 1);
      lvl_q <= 1'b0;
    end else begin
      if (i_go) begin
        left_q <= i_npulse;
      end else if (fire_w) begin
        left_q <= left_q - 8'h01;
      end
      if (fire_w) begin
        since_q <= 17'h00000;
      end else if (!ready_w) begin
        since_q <= since_q + 17'h00001;
      end
      lvl_q <= fire_w || (lvl_q && since_q < 17'(HIGH - 1));
    end
  end
  // Contact levels, pulse source on contact 3
  assign o_term = {i_close[3] | lvl_q, i_close[2:0]};
  assign o_busy = (left_q != 8'h00) || i_go || lvl_q;
endmodule

// *** bench/dtio_top_bench.sv ***
// Self-checking bench for the drive terminal I/O logic.
// Assumes dtio_pkg and dtio_contacts are compiled first.
`timescale 1ns/100ps
module dtio_top_bench;
  import dtio_pkg::*;
  localparam int FILT = 20;
  logic clk, arst_n, fload, trim, go, busy, trim_keep, uv, relay;
  logic [3:0] close, term;
  logic [23:0] funcs;
  logic [5:0] rsel;
  logic [24:0] ftime;
  logic [1:0] method;
  logic [7:0] npulse;
  logic [15:0] count;
  logic [31:0] rnd;
  dtio_status_t status;
  dtio_cmd_t cmd;
  dtio_dir_t dir;
  int fails, cmp_count, n;
  int srcs[13] = '{1, 2, 3, 4, 7, 8, 9, 10, 11, 12, 13, 14, 15};
  // Design and contacts
  dtio_top #(.FILT_DEF(FILT)) dtio_top_i (.i_clk(clk), .i_arst_n(arst_n), .i_term(term),
    .i_term_func(funcs), .i_relay_source_select(rsel), .i_relay_filter_time(ftime),
    .i_filter_load(fload), .i_terminal_control_method(method), .i_trim_save_option(trim),
    .i_status(status), .o_cmd(cmd), .o_dir(dir), .o_trim_keep(trim_keep), .o_uv_alarm(uv),
    .o_count(count), .o_programmable_relay(relay));
  dtio_contacts dtio_contacts_i (.i_clk(clk), .i_arst_n(arst_n), .i_close(close),
    .i_npulse(npulse), .i_go(go), .o_term(term), .o_busy(busy));
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // Expected commands from terminal levels and codes
  function automatic dtio_cmd_t exp_cmd(input logic [3:0] t, input logic [23:0] f);
    dtio_cmd_t c;
    logic [5:0] k;
    c = '0;
    for (int i = 0; i < 4; i++) begin
      k = f[6*i +: 6];
      if (t[i]) begin
        case (k)
          6'h09, 6'h0a, 6'h0b, 6'h0c: c.speed_sel[k[1:0] - 2'h1] = 1'b1;
          6'h0d: c.ramp_sel[0] = 1'b1;
          6'h0e: c.ramp_sel[1] = 1'b1;
          6'h0f: c.freq_up = 1'b1;
          6'h10: c.freq_down = 1'b1;
          6'h11: c.halt = 1'b1;
          6'h12: c.fault_clr = 1'b1;
          6'h13: c.pid_en = 1'b1;
          6'h14: c.seq_start = 1'b1;
          6'h15: c.tmr1_run = 1'b1;
          6'h16: c.tmr2_run = 1'b1;
          6'h19: c.pause = 1'b1;
          6'h1a: c.chan_y = 1'b1;
          default: ;
        endcase
      end
    end
    if (c.freq_up && c.freq_down) begin
      c.freq_up = 1'b0;
      c.freq_down = 1'b0;
    end
    return c;
  endfunction
  function automatic dtio_dir_t exp_dir(input logic [3:0] t, input logic [23:0] f, input logic [1:0] m);
    logic fw;
    logic rv;
    fw = 1'b0;
    rv = 1'b0;
    for (int i = 0; i < 4; i++) begin
      fw |= t[i] && f[6*i +: 6] == 6'h06;
      rv |= t[i] && f[6*i +: 6] == 6'h07;
    end
    if (m != 2'h0 || fw == rv) return DTIO_DIR_STOP;
    return fw ? DTIO_DIR_FWD : DTIO_DIR_REV;
  endfunction
  task automatic wrap_up();
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic timeout();
    fails++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask
  task automatic settle(input int m);
    repeat (m) @(posedge clk);
    @(negedge clk);
  endtask
  // Apply terminals for one registered step and compare
  task automatic step_cmd(input logic [3:0] t, input logic [23:0] f, input logic [1:0] m, input logic tr);
    @(posedge clk);
    close <= t;
    funcs <= f;
    method <= m;
    trim <= tr;
    settle(1);
    chk(cmd, exp_cmd(t, f), "command");
    chk(dir, exp_dir(t, f, m), "direction");
    chk(trim_keep, tr, "trim keep");
  endtask
  task automatic wait_relay(input logic lvl);
    for (n = 0; relay !== lvl; n++) begin
      if (n == 40) timeout();
      @(negedge clk);
    end
  endtask
  task automatic burst(input logic [7:0] k);
    @(posedge clk);
    npulse <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    for (int i = 0; busy === 1'b1; i++) begin
      if (i == 90000) timeout();
      @(negedge clk);
    end
    settle(3);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    close = 4'h0;
    funcs = 24'h0;
    rsel = RS_DEF;
    ftime = 25'h0;
    fload = 1'b0;
    method = 2'h0;
    trim = 1'b0;
    status = '0;
    npulse = 8'h00;
    go = 1'b0;
    fails = 0;
    cmp_count = 0;
    rnd = 32'h40fb;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk(cmd, 16'h0, "reset command");
    chk(relay, 1'b0, "reset relay");
    chk(count, 16'h0, "reset count");
    // Default source and default filter on both edges
    @(posedge clk);
    status.fault <= 1'b1;
    wait_relay(1'b1);
    chk(n >= FILT && n <= FILT + 3, 1'b1, "filter rise");
    @(posedge clk);
    status.fault <= 1'b0;
    wait_relay(1'b0);
    chk(n >= FILT && n <= FILT + 3, 1'b1, "filter fall");
    @(posedge clk);
    fload <= 1'b1;
    @(posedge clk);
    fload <= 1'b0;
    // Every code on all terminals, speed patterns, raise and lower, directions
    for (int c = 0; c < 64; c++) step_cmd(4'hf, {4{6'(c)}}, 2'h0, c[0]);
    for (int p = 0; p < 16; p++) step_cmd(4'(p), 24'h30b289, 2'h0, 1'b0);
    step_cmd(4'h3, 24'h00040f, 2'h0, 1'b1);
    for (int p = 0; p < 4; p++) step_cmd(4'(p), 24'h1c6, 2'h0, 1'b0);
    repeat (300) begin
      rnd = lfsr(rnd);
      step_cmd(rnd[3:0], rnd[27:4], rnd[28] ? rnd[30:29] : 2'h0, rnd[31]);
    end
    // Counter clear, clear over a pulse, one counted pulse, clear again
    step_cmd(4'h4, 24'h5d8000, 2'h0, 1'b0);
    chk(count, 16'h0, "count clear");
    burst(8'd1);
    chk(count, 16'h0, "clear priority");
    step_cmd(4'h0, 24'h5d8000, 2'h0, 1'b0);
    burst(8'd1);
    chk(count, 16'h1, "count one");
    step_cmd(4'h4, 24'h5d8000, 2'h0, 1'b0);
    chk(count, 16'h0, "count cleared again");
    // Each relay source against its own status bit
    step_cmd(4'h3, 24'h000595, 2'h0, 1'b0);
    for (int k = 0; k < 13; k++) begin
      @(posedge clk);
      rsel <= 6'(srcs[k]);
      status <= (k == 9 || k == 10) ? 13'h0 : ~(13'h1 << (12 - k));
      settle(4);
      chk({relay, uv}, 2'b00, "relay off");
      @(posedge clk);
      status <= 13'h1 << (12 - k);
      if (k == 9 || k == 10) begin
        @(posedge clk);
        status <= '0;
        n = 0;
        repeat (6) begin
          @(negedge clk);
          n += (relay === 1'b1);
        end
        chk(n, 1, "relay pulse");
      end else begin
        settle(4);
        chk({relay, uv}, {1'b1, k == 6}, "relay on");
      end
    end
    // Timer source drops with its trigger
    @(posedge clk);
    rsel <= RS_TMR1;
    status <= 13'h20;
    settle(4);
    chk(relay, 1'b1, "timer on");
    @(posedge clk);
    close <= 4'h2;
    settle(4);
    chk(relay, 1'b0, "timer off");
    // No-function and reserved sources stay off
    foreach (srcs[k]) srcs[k] = (k * 13) % 64;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      rsel <= 6'(k == 0 ? 0 : srcs[k + 4] | 6'h20);
      status <= '1;
      settle(4);
      chk(relay, 1'b0, "reserved source");
    end
    wrap_up();
  end
endmodule
